// ===== rtl/arbr_readout.sv
// Result readout of a 16-bit converter: busy flag, parallel and serial bus.
// Assumes the converter core holds conv_result_in steady at end of conversion.
`timescale 1ns/1ps
`default_nettype none
`include "arbr_params.svh"
module arbr_readout import arbr_pkg::*; #(
    parameter int DEPTH = `ARBR_FIFO_DEPTH,
    parameter int CONV_CYCLES = `ARBR_CONV_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic conversion_start,
    input wire logic cs_n,
    input wire logic bus_format_select,
    input wire logic reserved_format_select,
    input wire logic reserved_address_bit,
    input wire logic byte_swap_select,
    input wire logic input_range_select,
    input wire logic output_code_select,
    input wire logic [15:0] conv_result_in,
    input wire logic [15:0] bus_in,
    output logic [15:0] bus_out,
    output logic [15:0] bus_oe,
    output logic busy
);
    localparam int NS = 8;
    localparam int I_CNV = 0;
    localparam int I_CS = 1;
    localparam int I_SCK = 2;
    localparam int I_SDI = 3;
    localparam int I_MODE = 4;
    localparam int I_SWAP = 5;
    localparam int I_RNG = 6;
    localparam int I_CODE = 7;
    localparam int CW = $clog2(CONV_CYCLES + 1);

    // Straps
    function automatic logic [15:0] fmt(input logic [15:0] raw, input logic rng,
                                        input logic code);
        // Core delivers two's complement; offset and straight binary flip the MSB
        fmt = code ? (raw ^ `ARBR_MSB_FLIP) : raw;
        if (!rng && !code) begin
            fmt = raw;
        end
    endfunction

    // Input synchronisers: a change counts once stages two and three agree
    logic [NS-1:0] pins, s1_r, s2_r, s3_r, st_r, st_nxt, prev_r;
    assign pins = {output_code_select, input_range_select, byte_swap_select,
                   bus_format_select, bus_in[`ARBR_SDI_BIT], bus_in[`ARBR_SCK_BIT],
                   cs_n, conversion_start};

    always_comb begin
        st_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & st_r);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_r <= `ARBR_SYNC_RST;
            s2_r <= `ARBR_SYNC_RST;
            s3_r <= `ARBR_SYNC_RST;
            st_r <= `ARBR_SYNC_RST;
            prev_r <= `ARBR_SYNC_RST;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            st_r <= st_nxt;
            prev_r <= st_r;
        end
    end

    logic cnv_fall, cs_low, serial, rd_start, sck_rise, sck_fall;
    assign cnv_fall = prev_r[I_CNV] && !st_r[I_CNV];
    assign cs_low = !st_r[I_CS];
    assign serial = st_r[I_MODE];
    assign rd_start = prev_r[I_CS] && cs_low && serial;
    // Shift clock edges only count while selected
    assign sck_rise = cs_low && !prev_r[I_SCK] && st_r[I_SCK];
    assign sck_fall = cs_low && prev_r[I_SCK] && !st_r[I_SCK];

    // Conversion sequencing
    arbr_state_e state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [15:0] fifo_out_data, coded;

    assign coded = fmt(conv_result_in, st_r[I_RNG], st_r[I_CODE]);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ARBR_IDLE: begin
                // Start is taken without regard to chip select
                if (cnv_fall) begin
                    state_nxt = ARBR_CONV;
                    cnt_nxt = CW'(CONV_CYCLES - 1);
                end
            end
            ARBR_CONV: begin
                if (cnt_r == '0) begin
                    state_nxt = ARBR_PUSH;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ARBR_PUSH: begin
                // A full FIFO stretches busy rather than dropping the result
                if (fifo_in_ready) begin
                    state_nxt = ARBR_IDLE;
                end
            end
            default: state_nxt = ARBR_IDLE;
        endcase
        busy_nxt = (state_nxt != ARBR_IDLE);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ARBR_IDLE;
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end

    // Words are only drained while the host is not selecting the device
    arbr_fifo #(
        .W(16),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(state_r == ARBR_PUSH),
        .in_data(coded),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(!cs_low)
    );
    assign fifo_pop = fifo_out_valid && !cs_low;

    // Presented word and serial shifter
    logic [15:0] word_r, word_nxt, shift_r, shift_nxt;

    always_comb begin
        word_nxt = fifo_pop ? fifo_out_data : word_r;
        shift_nxt = shift_r;
        if (rd_start) begin
            shift_nxt = word_r;
        end else if (sck_rise) begin
            // Each rise moves the word up one place and frees the bottom slot
            shift_nxt = {shift_r[14:0], 1'b0};
        end else if (sck_fall) begin
            // Chain level taken at the fall fills the freed slot, so the level
            // of the first period leaves after sixteen rises, not seventeen
            shift_nxt[0] = st_r[I_SDI];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            word_r <= '0;
            shift_r <= '0;
        end else begin
            word_r <= word_nxt;
            shift_r <= shift_nxt;
        end
    end

    // Pin drive
    logic [15:0] bus_out_r, bus_out_nxt, bus_oe_r, bus_oe_nxt;

    always_comb begin
        bus_out_nxt = '0;
        bus_oe_nxt = '0;
        if (cs_low) begin
            if (!serial) begin
                bus_oe_nxt = `ARBR_OE_ALL;
                bus_out_nxt = st_r[I_SWAP] ? {word_r[7:0], word_r[15:8]} : word_r;
            end else begin
                // Swap strap is ignored here
                bus_oe_nxt = `ARBR_OE_SDO;
                bus_out_nxt[`ARBR_SDO_BIT] = shift_nxt[15];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_out_r <= '0;
            bus_oe_r <= '0;
        end else begin
            bus_out_r <= bus_out_nxt;
            bus_oe_r <= bus_oe_nxt;
        end
    end

    assign bus_out = bus_out_r;
    assign bus_oe = bus_oe_r;
    assign busy = busy_r;

    a_busy_rise: assert property (@(posedge clk) disable iff (sys_rst)
        cnv_fall && state_r == ARBR_IDLE |=> busy_r) else $error("busy did not rise");
    a_busy_hold: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(busy_r) |-> busy_r [*8]) else $error("busy fell too early");
    a_cs_release: assert property (@(posedge clk) disable iff (sys_rst)
        !cs_low |=> bus_oe_r == '0) else $error("bus driven while deselected");
    a_par_oe: assert property (@(posedge clk) disable iff (sys_rst)
        cs_low && !serial |=> bus_oe_r == `ARBR_OE_ALL) else $error("parallel enable wrong");
    a_ser_oe: assert property (@(posedge clk) disable iff (sys_rst)
        cs_low && serial |=> bus_oe_r == `ARBR_OE_SDO) else $error("serial enable wrong");
    a_byte_straight: assert property (@(posedge clk) disable iff (sys_rst)
        cs_low && !serial && !st_r[I_SWAP] |=> bus_out_r == $past(word_r))
        else $error("straight byte map wrong");
    a_byte_swap: assert property (@(posedge clk) disable iff (sys_rst)
        cs_low && !serial && st_r[I_SWAP] |=>
        bus_out_r == {$past(word_r[7:0]), $past(word_r[15:8])}) else $error("swap map wrong");
    a_sdo_msb: assert property (@(posedge clk) disable iff (sys_rst)
        rd_start |=> bus_out_r[`ARBR_SDO_BIT] == $past(word_r[15])) else $error("MSB not first");
    a_reset_abort: assert property (@(posedge clk)
        sys_rst |=> !busy_r && bus_oe_r == '0) else $error("reset did not abort");
endmodule
`default_nettype wire

// ===== rtl/arbr_params.svh
// Timing counts, pin positions and reset values for the result readout.
// Assumes the includer runs on a 100 MHz clock.
`ifndef ARBR_PARAMS_SVH
`define ARBR_PARAMS_SVH

`define ARBR_W 16
`define ARBR_FIFO_DEPTH 4
`define ARBR_CLK_MHZ 100
// Conversion time of the core; arbitrary plain default
`define ARBR_CONV_TIME_NS 300
// Least time, rounded up to whole cycles
`define ARBR_CONV_CYCLES ((`ARBR_CONV_TIME_NS * `ARBR_CLK_MHZ + 999) / 1000)

`define ARBR_SCK_BIT 11
`define ARBR_SDO_BIT 10
`define ARBR_SDI_BIT 9

`define ARBR_SYNC_RST 8'h03
`define ARBR_OE_ALL 16'hFFFF
`define ARBR_OE_SDO 16'h0400
`define ARBR_MSB_FLIP 16'h8000

`endif

// ===== rtl/arbr_pkg.sv
// Types shared by the result readout files.
// Assumes arbr_params.svh is on the include path.
`default_nettype none
package arbr_pkg;
    typedef enum logic [1:0] {
        ARBR_IDLE = 2'h0,
        ARBR_CONV = 2'h1,
        ARBR_PUSH = 2'h3
    } arbr_state_e;
endpackage
`default_nettype wire

// ===== rtl/arbr_fifo.sv
// Small flip-flop FIFO between finished conversions and the output word.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module arbr_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem_r [DEPTH];
    logic [W-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic push, pop;

    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready = (cnt_r != CW'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wp_r] = in_data;
            wp_nxt = step(wp_r);
        end
        if (pop) begin
            rp_nxt = step(rp_r);
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        mem_r <= mem_nxt;
        if (sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== tb/arbr_host.sv
// Host side of the result bus: makes the shift clock, feeds the chain input.
// Assumes the bench resolves every pin from the device enables and drv.
`timescale 1ns/1ps
`default_nettype none
module arbr_host (
    input wire logic [15:0] pins,
    output logic [15:0] drv
);
    logic sck = 1'b0;
    logic serial_chain_in = 1'b0;
    logic noise = 1'b0;
    // Pins nobody drives toggle, so stale data can never pass for a bit
    always #5 noise = ~noise;
    assign drv = {{4{noise}}, sck, ~noise, serial_chain_in, {9{noise}}};
    // Clock idles low between frames; bit taken at the start of each low half, 62.5 ns before the rise
    task automatic shift(input logic d, output logic q);
        q = pins[10];
        serial_chain_in = d;
        #62.5 sck = 1'b1;
        #62.5 sck = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the converter result readout.
// Assumes arbr_readout with its FIFO; host model drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: %h not %h", $time, (a), (e)); end end
module tb_top;
    localparam int CV = 8;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cst = 1'b1;
    logic cs_n = 1'b1;
    logic fmt = 1'b0;
    logic swap = 1'b0;
    logic rng = 1'b0;
    logic code = 1'b0;
    logic [15:0] res = 16'h0000;
    logic [15:0] pins, drv, bus_out, bus_oe;
    logic busy;
    int n_fail = 0;
    int total_checks = 0;
    assign pins = (bus_oe & bus_out) | (~bus_oe & drv);
    initial forever #5 clk = ~clk;
    // Reserved straps held low by the board
    arbr_readout #(.DEPTH(4), .CONV_CYCLES(CV)) i_dut (.clk(clk), .sys_rst(sys_rst),
        .conversion_start(cst), .cs_n(cs_n), .bus_format_select(fmt),
        .reserved_format_select(1'b0), .reserved_address_bit(1'b0),
        .byte_swap_select(swap), .input_range_select(rng), .output_code_select(code),
        .conv_result_in(res), .bus_in(pins), .bus_out(bus_out), .bus_oe(bus_oe),
        .busy(busy));
    arbr_host i_host (.pins(pins), .drv(drv));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_busy(input logic lvl, input int lim, output int n);
        n = 0;
        while (busy !== lvl) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                n_fail++;
                $display("unexpected at %0t: busy wait ran out", $time);
                end_of_test();
            end
        end
    endtask
    task automatic start(input logic [15:0] v);
        int n;
        res = v;
        cst = 1'b0;
        wait_busy(1'b1, 20, n);
        cst = 1'b1;
    endtask
    task automatic conv(input logic [15:0] v);
        int n;
        start(v);
        wait_busy(1'b0, CV + 10, n);
        `CHK(n >= CV, 1'b1)
    endtask
    task automatic par_read(input logic [15:0] w);
        swap = 1'b0;
        cs_n = 1'b0;
        repeat (8) @(negedge clk);
        `CHK(bus_oe, 16'hFFFF)
        `CHK(bus_out, w)
        swap = 1'b1;
        repeat (8) @(negedge clk);
        `CHK(bus_out, {w[7:0], w[15:8]})
        cs_n = 1'b1;
        repeat (8) @(negedge clk);
        `CHK(bus_oe, 16'h0000)
    endtask
    task automatic ser_read(input logic [15:0] w, input logic d);
        logic q;
        cs_n = 1'b0;
        repeat (8) @(negedge clk);
        `CHK(bus_oe, 16'h0400)
        // Offset keeps every shift clock edge clear of the sampling clock edges
        #1.25;
        for (int i = 15; i >= 0; i--) begin
            i_host.shift(d, q);
            `CHK(q, w[i])
        end
        i_host.shift(1'b0, q);
        `CHK(q, d)
        @(negedge clk);
        cs_n = 1'b1;
        repeat (8) @(negedge clk);
        `CHK(bus_oe, 16'h0000)
    endtask
    // Five results while selected: the fifth must wait for FIFO space
    task automatic fill();
        int n;
        cs_n = 1'b0;
        repeat (8) @(negedge clk);
        for (int k = 1; k <= 4; k++) conv(16'h1111 * k[15:0]);
        start(16'h5555);
        repeat (CV + 8) @(negedge clk);
        `CHK(busy, 1'b1)
        cs_n = 1'b1;
        wait_busy(1'b0, 20, n);
        repeat (10) @(negedge clk);
        par_read(16'h5555);
    endtask
    task automatic rst_mid();
        cs_n = 1'b0;
        start(16'h0F0F);
        repeat (3) @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(busy, 1'b0)
        `CHK(bus_oe, 16'h0000)
        sys_rst = 1'b0;
        cs_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        fmt = 1'b1;
        swap = 1'b1;
        // Swap left high in serial form must change nothing
        for (int k = 0; k < 4; k++) begin
            {rng, code} = k[1:0];
            repeat (8) @(negedge clk);
            conv(k[0] ? 16'hC3A5 : 16'h3A5C);
            ser_read((k[0] ? 16'hC3A5 : 16'h3A5C) ^ {code, 15'h0000}, k[1]);
        end
        {rng, code} = 2'b00;
        fmt = 1'b0;
        repeat (8) @(negedge clk);
        conv(16'h8001);
        par_read(16'h8001);
        fill();
        rst_mid();
        end_of_test();
    end
endmodule
`default_nettype wire
